//--- tmcs_chsel.sv
// Purpose: Measurement channel select register with scan sequencer
// Assumes: AXI4-Lite master keeps one write and one read in flight
// Notes:   Contract
// Contract
// R01 - Single scan measures the receive pin coded in the receive field, 0 to 35.
// R02 - Software never starts after writing a receive code above 35.
// R03 - Outside single scan, receive field shows current pin, all ones when stopped.
// R04 - Single scan drives the transmit pin coded in the transmit field.
// R05 - Multi scan transmit field reads back the transmit pin being measured.
// R06 - Four independent multi-clock enable bits are held in the register.
// R07 - Byte view puts the transmit field in bits 5 to 0.
// R08 - In single scan mode, scanning or idle, channel fields read back what software wrote.
//
// Design decisions made here: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
module tmcs_chsel
    import tmcs_pkg::*;
(
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [ADDR_W-1:0] awaddr,
    input  wire logic              awvalid,
    output logic                   awready,
    input  wire logic [31:0]       wdata,
    input  wire logic [3:0]        wstrb,
    input  wire logic              wvalid,
    output logic                   wready,
    output logic [1:0]             bresp,
    output logic                   bvalid,
    input  wire logic              bready,
    input  wire logic [ADDR_W-1:0] araddr,
    input  wire logic              arvalid,
    output logic                   arready,
    output logic [31:0]            rdata,
    output logic [1:0]             rresp,
    output logic                   rvalid,
    input  wire logic              rready,
    output logic [5:0]             sense_rx_sel,
    output logic [5:0]             sense_tx_sel,
    output logic                   sense_active,
    output logic [3:0]             multiclock_enable
);
    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [1:0]  rresp;
        logic [31:0] rdata;
        logic [5:0]  sw_rx;
        logic [5:0]  sw_tx;
        logic [3:0]  mca;
        logic        multi;
        tmcs_seq_e   seq;
        logic [5:0]  cur_rx;
        logic [5:0]  cur_tx;
        logic        busy;
    } tmcs_state_s;

    tmcs_state_s s;
    tmcs_state_s next_s;
    logic        dwell_done;
    logic        start_req;
    logic        stop_req;
    logic        wr_take;
    logic        rd_take;
    logic [31:0] merged;
    logic [31:0] cur_word;

    // Byte-lane merge of a write into an old word
    function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d,
                                           input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = d[i*8 +: 8];
            end
        end
        return r;
    endfunction : wmerge

    // Packs the channel word; multi mode shows the live pins instead of the stored code
    function automatic logic [31:0] mch_word(input tmcs_state_s st);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[RX_LSB +: 6]  = st.multi ? st.cur_rx : st.sw_rx;   // R03 R08
        w[TX_LSB +: 6]  = st.multi ? st.cur_tx : st.sw_tx;   // R05 R08
        w[MCA_LSB +: 4] = st.mca;                            // R06
        return w;
    endfunction : mch_word

    // Word as software sees it; a call result cannot be part-selected directly
    assign cur_word = mch_word(s);

    tmcs_dwell tmcs_dwell_inst (
        .aclk    (aclk),
        .aresetn (aresetn),
        .run     (s.seq != TMCS_IDLE),
        .done    (dwell_done)
    );

    assign wr_take = s.awready && awvalid && wvalid;
    assign rd_take = s.arready && arvalid;

    // Bus slave and scan sequencer; ready pulses one cycle, so answers lag a clock
    always_comb begin
        next_s         = s;
        next_s.awready = 1'b0;
        next_s.wready  = 1'b0;
        next_s.arready = 1'b0;
        start_req      = 1'b0;
        stop_req       = 1'b0;
        merged         = wmerge(cur_word, wdata, wstrb);
        if (s.bvalid && bready) begin
            next_s.bvalid = 1'b0;
        end
        if (s.rvalid && rready) begin
            next_s.rvalid = 1'b0;
        end
        if (wr_take) begin
            next_s.bvalid = 1'b1;
            next_s.bresp  = RESP_OKAY;
            case (awaddr)
                OFF_MCH: begin
                    next_s.sw_rx = merged[RX_LSB +: 6];
                    next_s.sw_tx = merged[TX_LSB +: 6];
                    next_s.mca   = merged[MCA_LSB +: 4];          // R06
                end
                OFF_TXB: begin
                    if (wstrb[0]) begin
                        next_s.sw_tx = wdata[5:0];                // R07
                    end
                end
                OFF_CTRL: begin
                    if (wstrb[0]) begin
                        if (s.seq == TMCS_IDLE) begin
                            next_s.multi = wdata[MODE_BIT];
                        end
                        start_req = wdata[START_BIT];
                        stop_req  = wdata[STOP_BIT];
                    end
                end
                default: next_s.bresp = RESP_SLVERR;
            endcase
        end else if (!s.awready && !s.bvalid && awvalid && wvalid) begin
            next_s.awready = 1'b1;
            next_s.wready  = 1'b1;
        end
        if (rd_take) begin
            next_s.rvalid = 1'b1;
            next_s.rresp  = RESP_OKAY;
            case (araddr)
                OFF_MCH:  next_s.rdata = cur_word;
                OFF_TXB:  next_s.rdata = {26'h000_0000, cur_word[TX_LSB +: 6]};
                OFF_CTRL: next_s.rdata = {29'h0000_0000, 1'b0, s.multi,
                                          s.seq != TMCS_IDLE};
                default: begin
                    next_s.rdata = 32'h0000_0000;
                    next_s.rresp = RESP_SLVERR;
                end
            endcase
        end else if (!s.arready && !s.rvalid && arvalid) begin
            next_s.arready = 1'b1;
        end
        // Out-of-range codes are refused rather than driving a missing pin
        case (s.seq)
            TMCS_IDLE: begin
                if (start_req && !next_s.multi) begin
                    if (s.sw_rx <= PIN_LAST && s.sw_tx <= PIN_LAST) begin   // R02
                        next_s.seq    = TMCS_SINGLE;
                        next_s.cur_rx = s.sw_rx;                          // R01
                        next_s.cur_tx = s.sw_tx;                          // R04
                    end
                end else if (start_req) begin
                    next_s.seq    = TMCS_MULTI;
                    next_s.cur_rx = PIN_FIRST;
                    next_s.cur_tx = PIN_FIRST;
                end
            end
            TMCS_SINGLE: begin
                if (stop_req || dwell_done) begin
                    next_s.seq    = TMCS_IDLE;
                    next_s.cur_rx = CH_STOPPED;
                    next_s.cur_tx = CH_STOPPED;
                end
            end
            TMCS_MULTI: begin
                if (stop_req || (dwell_done && s.cur_rx == PIN_LAST)) begin
                    next_s.seq    = TMCS_IDLE;
                    next_s.cur_rx = CH_STOPPED;                           // R03
                    next_s.cur_tx = CH_STOPPED;
                end else if (dwell_done) begin
                    next_s.cur_rx = s.cur_rx + 6'h01;                     // R03
                    next_s.cur_tx = s.cur_tx + 6'h01;                     // R05
                end
            end
            default: next_s.seq = TMCS_IDLE;
        endcase
        // Registered busy so sense_active leaves a flip-flop directly
        next_s.busy = (next_s.seq != TMCS_IDLE);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s        <= '0;
            s.bresp  <= RESP_OKAY;
            s.rresp  <= RESP_OKAY;
            s.sw_rx  <= RST_CH;
            s.sw_tx  <= RST_CH;
            s.mca    <= RST_MCA;
            s.seq    <= TMCS_IDLE;
            s.cur_rx <= CH_STOPPED;
            s.cur_tx <= CH_STOPPED;
        end else begin
            s <= next_s;
        end
    end

    // All outputs straight from the state register
    assign awready           = s.awready;
    assign wready            = s.wready;
    assign bvalid            = s.bvalid;
    assign bresp             = s.bresp;
    assign arready           = s.arready;
    assign rvalid            = s.rvalid;
    assign rresp             = s.rresp;
    assign rdata             = s.rdata;
    assign sense_rx_sel      = s.cur_rx;
    assign sense_tx_sel      = s.cur_tx;
    assign sense_active      = s.busy;
    assign multiclock_enable = s.mca;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    AST_SINGLE_RX: assert property ($rose(sense_active) && !s.multi |->   // R01
        sense_rx_sel == $past(s.sw_rx)) else $error("single scan receive pin wrong");
    AST_SINGLE_TX: assert property ($rose(sense_active) && !s.multi |->   // R04
        sense_tx_sel == $past(s.sw_tx)) else $error("single scan transmit pin wrong");
    AST_BAD_CODE: assert property (s.seq == TMCS_IDLE && start_req && !next_s.multi && // R02
        s.sw_rx > PIN_LAST |=> !sense_active) else $error("started on bad code");
    AST_STOP_ONES: assert property (s.multi && s.seq == TMCS_IDLE |->     // R03
        cur_word[RX_LSB +: 6] == CH_STOPPED) else $error("stopped field not all ones");
    AST_MULTI_STEP: assert property (s.seq == TMCS_MULTI && dwell_done && !stop_req && // R03
        s.cur_rx != PIN_LAST |=> sense_rx_sel == $past(s.cur_rx) + 6'h01)
        else $error("multi scan did not step");
    AST_TX_TRACK: assert property (rd_take && araddr == OFF_MCH && s.seq == TMCS_MULTI |=> // R05
        rdata[TX_LSB +: 6] == $past(s.cur_tx)) else $error("transmit field not live");
    AST_MCA: assert property (wr_take && awaddr == OFF_MCH && wstrb[2] |=> // R06
        multiclock_enable == $past(wdata[MCA_LSB +: 4])) else $error("multiclock not stored");
    AST_TXB: assert property (wr_take && awaddr == OFF_TXB && wstrb[0] |=> // R07
        s.sw_tx == $past(wdata[5:0])) else $error("byte view write lost");
    AST_READBACK: assert property (rd_take && araddr == OFF_MCH && !s.multi |=> // R08
        rvalid && rdata[RX_LSB +: 6] == $past(s.sw_rx)) else $error("readback mismatch");
    AST_BRESP: assert property (wr_take |=> bvalid ##0 $past(s.bvalid) == 1'b0 [*1])
        else $error("write response late");
endmodule : tmcs_chsel

//--- tmcs_chsel_tb.sv
// Purpose: Self-checking bench for the channel select register and scan
// Assumes: Design answers per the hand-over contract, 40 MHz aclk
// Notes:   Bad-code start is expected to be ignored by the device
`timescale 1ns/1ps
module tmcs_chsel_tb
    import tmcs_pkg::*;
;
    localparam int TMO_CYC = 20000;
    logic              aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic [ADDR_W-1:0] awaddr, araddr;
    logic [31:0]       wdata, rdata, d;
    logic [3:0]        wstrb, multiclock_enable, mca;
    logic [1:0]        bresp, rresp;
    logic              awready, wready, bvalid, arready, rvalid, sense_active;
    logic [5:0]        sense_rx_sel, sense_tx_sel, rx, tx, prev;
    int                num_errors, n_compared, cycles, steps, seed;

    tmcs_chsel tmcs_chsel_inst (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .sense_rx_sel(sense_rx_sel), .sense_tx_sel(sense_tx_sel),
        .sense_active(sense_active), .multiclock_enable(multiclock_enable));

    // Free-running bus clock
    initial begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end

    // Expected register word from field values
    function automatic logic [31:0] mch_word(input logic [5:0] r, t, input logic [3:0] m);
        return {12'h000, m, 2'b00, t, 2'b00, r};
    endfunction : mch_word

    task automatic results();
        if (num_errors == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : results

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // Write: valids held until each ready, response awaited without a cycle guess
    task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s,
                      input logic [1:0] er);
        logic       aw_seen, w_seen, b_seen;
        logic [1:0] resp;
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= v;
        wstrb   <= s;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        // Settled values at the falling edge are what the next rising edge samples
        do begin
            @(negedge aclk);
            aw_seen = awready;
            w_seen  = wready;
            b_seen  = bvalid;
            resp    = bresp;
            @(posedge aclk);
            if (aw_seen) awvalid <= 1'b0;
            if (w_seen) wvalid <= 1'b0;
        end while (!b_seen);
        chk(32'(resp), 32'(er));
        bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] v);
        logic       ar_seen, r_seen;
        logic [1:0] resp;
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(negedge aclk);
            ar_seen = arready;
            r_seen  = rvalid;
            v       = rdata;
            resp    = rresp;
            @(posedge aclk);
            if (ar_seen) arvalid <= 1'b0;
        end while (!r_seen);
        chk(32'(resp), 32'(er));
        rready <= 1'b0;
    endtask : rd

    // Hang guard: a run past the ceiling counts as a failure
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == TMO_CYC) begin
            num_errors++;
            results();
        end
    end

    initial begin
        seed = $urandom(68085);
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata, wstrb} = '0;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        @(negedge aclk);
        chk(32'(sense_rx_sel), 32'(CH_STOPPED));
        rd(OFF_MCH, RESP_OKAY, d);
        chk(d, 32'h0000_0000);
        // Single scans: pin corners first, then random codes and enables
        for (int i = 0; i < 6; i++) begin
            rx  = (i == 0) ? PIN_FIRST : (i == 1) ? PIN_LAST : 6'($urandom_range(35));
            tx  = (i == 0) ? PIN_LAST : (i == 1) ? PIN_FIRST : 6'($urandom_range(35));
            mca = (i == 0) ? 4'h5 : (i == 1) ? 4'hA : 4'($urandom);
            wr(OFF_MCH, mch_word(rx, tx, mca), 4'hF, RESP_OKAY);
            rd(OFF_MCH, RESP_OKAY, d);
            chk(d, mch_word(rx, tx, mca));
            chk(32'(multiclock_enable), 32'(mca));
            rd(OFF_TXB, RESP_OKAY, d);
            chk(d, 32'(tx));
            wr(OFF_CTRL, 32'h0000_0001, 4'hF, RESP_OKAY);
            @(negedge aclk);
            chk(32'(sense_active), 32'h0000_0001);
            chk(32'(sense_rx_sel), 32'(rx));
            chk(32'(sense_tx_sel), 32'(tx));
            repeat (DWELL_CYC + 4) @(posedge aclk);
            @(negedge aclk);
            chk(32'(sense_active), 32'h0000_0000);
        end
        // Byte view writes only the transmit field
        wr(OFF_TXB, 32'hFFFF_FF11, 4'h1, RESP_OKAY);
        rd(OFF_MCH, RESP_OKAY, d);
        chk(d, mch_word(rx, 6'h11, mca));
        // Out-of-range receive code: start must not run
        wr(OFF_MCH, mch_word(6'h24, tx, mca), 4'hF, RESP_OKAY);
        wr(OFF_CTRL, 32'h0000_0001, 4'hF, RESP_OKAY);
        @(negedge aclk);
        chk(32'(sense_active), 32'h0000_0000);
        rd(OFF_MCH, RESP_OKAY, d);
        chk(d, mch_word(6'h24, tx, mca));
        // Full multi scan: pins step upward, transmit follows receive
        wr(OFF_CTRL, 32'h0000_0003, 4'hF, RESP_OKAY);
        prev  = CH_STOPPED;
        steps = 0;
        repeat (36 * DWELL_CYC + 200) begin
            @(negedge aclk);
            if (sense_active && sense_rx_sel !== prev) begin
                chk(32'(sense_rx_sel), 32'(6'(prev + 6'h01)));
                chk(32'(sense_tx_sel), 32'(sense_rx_sel));
                prev = sense_rx_sel;
                steps++;
            end
        end
        chk(32'(steps), 32'(36));
        rd(OFF_MCH, RESP_OKAY, d);
        chk(d, mch_word(CH_STOPPED, CH_STOPPED, mca));
        // Second multi scan read live, then stopped mid-way
        wr(OFF_CTRL, 32'h0000_0003, 4'hF, RESP_OKAY);
        repeat (100) @(posedge aclk);
        rd(OFF_MCH, RESP_OKAY, d);
        chk(32'(d[13:8]), 32'(d[5:0]));
        chk(32'(d[5:0] == CH_STOPPED), 32'h0000_0000);
        wr(OFF_CTRL, 32'h0000_0006, 4'hF, RESP_OKAY);
        @(negedge aclk);
        @(negedge aclk);
        chk(32'(sense_active), 32'h0000_0000);
        rd(OFF_MCH, RESP_OKAY, d);
        chk(32'(d[5:0]), 32'(CH_STOPPED));
        wr(OFF_CTRL, 32'h0000_0000, 4'hF, RESP_OKAY);
        // Unmapped address: error response, no data
        wr(8'h0C, 32'hDEAD_BEEF, 4'hF, RESP_SLVERR);
        rd(8'h0C, RESP_SLVERR, d);
        chk(d, 32'h0000_0000);
        results();
    end
endmodule : tmcs_chsel_tb

//--- tmcs_pkg.sv
// Purpose: Constants and state types shared by the channel select block
// Assumes: 32-bit AXI4-Lite register window, 40 MHz aclk
// Notes:   Offsets are byte addresses
package tmcs_pkg;
    localparam int          ADDR_W        = 8;
    localparam logic [7:0]  OFF_MCH       = 8'h00;   // measurement_channel_select
    localparam logic [7:0]  OFF_CTRL      = 8'h04;   // Mode, start, stop, busy
    localparam logic [7:0]  OFF_TXB       = 8'h08;   // Byte view of transmit field
    localparam int          RX_LSB        = 0;
    localparam int          TX_LSB        = 8;
    localparam int          MCA_LSB       = 16;
    localparam int          START_BIT     = 0;
    localparam int          MODE_BIT      = 1;
    localparam int          STOP_BIT      = 2;
    localparam logic [5:0]  PIN_FIRST     = 6'h00;   // sense_pin_first
    localparam logic [5:0]  PIN_LAST      = 6'h23;   // sense_pin_last, code 100011
    localparam logic [5:0]  CH_STOPPED    = 6'h3F;   // All ones once stopped
    localparam logic [5:0]  RST_CH        = 6'h00;
    localparam logic [3:0]  RST_MCA       = 4'h0;
    localparam logic [1:0]  RESP_OKAY     = 2'b00;
    localparam logic [1:0]  RESP_SLVERR   = 2'b10;
    localparam int          CLK_PERIOD_PS = 25000;
    localparam int          DWELL_TIME_PS = 1000000; // Per-channel measurement time
    localparam int          DWELL_CYC     = (DWELL_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam logic [7:0]  DWELL_LAST    = 8'(DWELL_CYC - 1);

    typedef enum logic [1:0] {
        TMCS_IDLE   = 2'b00,
        TMCS_SINGLE = 2'b01,
        TMCS_MULTI  = 2'b10
    } tmcs_seq_e;
endpackage : tmcs_pkg

// Purpose: Per-channel dwell timer
// Assumes: run stays high for the whole scan
// Notes:   done is one clock long per finished channel
`timescale 1ns/1ps
module tmcs_dwell
    import tmcs_pkg::*;
(
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic run,
    output logic      done
);
    typedef struct packed {
        logic [7:0] cnt;
        logic       done;
    } tmcs_dwell_s;

    tmcs_dwell_s s;
    tmcs_dwell_s next_s;

    // Restart on every idle so a new scan gets a full dwell
    always_comb begin
        next_s      = s;
        next_s.done = 1'b0;
        if (!run) begin
            next_s.cnt = 8'h00;
        end else if (s.cnt == DWELL_LAST) begin
            next_s.cnt  = 8'h00;
            next_s.done = 1'b1;
        end else begin
            next_s.cnt = s.cnt + 8'h01;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign done = s.done;
endmodule : tmcs_dwell
